/* File: axil_front.sv */
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes the bank answers wr_ok and rd_data combinationally.
`timescale 1ns/10ps
`default_nettype none
`include "drive_bank_cfg.svh"
module axil_front (
   input  wire logic               sys_clk,
   input  wire logic               reset,
   input  wire logic [`ADDR_W-1:0] awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   input  wire logic [`ADDR_W-1:0] araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   output drive_bank_pkg::wr_req_s wr_req,
   output logic                    wr_go,
   input  wire logic               wr_ok,
   output logic [`IDX_W-1:0]       rd_idx,
   output logic                    rd_go,
   input  wire logic [15:0]        rd_data,
   input  wire logic               rd_ok
);
   // Address and data are captured independently, in either order
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         wr_req  <= '0;
      end else begin
         if (awvalid && awready) begin
            awready    <= 1'b0;
            wr_req.idx <= awaddr[`ADDR_W-1:`IDX_LSB];
         end else if (bvalid && bready) awready <= 1'b1;
         if (wvalid && wready) begin
            wready      <= 1'b0;
            wr_req.data <= wdata[`REG_W-1:0];
            wr_req.full <= &wstrb[1:0];
         end else if (bvalid && bready) wready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) wr_go <= 1'b0;
      else wr_go <= !awready && !wready && !bvalid && !wr_go;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) bvalid <= 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         arready <= 1'b1;
         rd_go   <= 1'b0;
         rd_idx  <= '0;
      end else begin
         rd_go <= arvalid && arready;
         if (arvalid && arready) begin
            arready <= 1'b0;
            rd_idx  <= araddr[`ADDR_W-1:`IDX_LSB];
         end else if (rvalid && rready) arready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= `RESP_OKAY;
      end else if (rd_go) begin
         rvalid <= 1'b1;
         rdata  <= {16'h0000, rd_ok ? rd_data : `RST_ZERO};
         rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) rvalid <= 1'b0;
   end
endmodule : axil_front
`default_nettype wire

/* File: drive_bank_cfg.svh */
// Constants of the speed-source parameter bank: indices, limits, resets.
// Assumes registers sit at byte address four times their index.
`ifndef DRIVE_BANK_CFG_SVH
`define DRIVE_BANK_CFG_SVH
`define ADDR_W          16
`define IDX_W           14
`define IDX_LSB         2
`define REG_W           16
`define IDX_SPEED_SRC   14'h1201
`define IDX_RUN_ORIGIN  14'h1202
`define IDX_BASE_SPEED  14'h1203
`define IDX_TOP_SPEED   14'h1204
`define IDX_SWITCH_MODE 14'h1205
`define IDX_SECOND_MODE 14'h1206
`define IDX_RSTART_SPD  14'h120B
`define IDX_REND_SPD    14'h120D
`define IDX_RSTART_VOLT 14'h120F
`define IDX_REND_VOLT   14'h1210
`define IDX_RSTART_BEH  14'h1211
`define IDX_FILTER      14'h1212
`define IDX_SEQ_ENABLE  14'h1213
`define IDX_MS_MODE     14'h1215
`define IDX_MS_BASE     14'h1216
`define IDX_MS_ONE      14'h1218
`define IDX_MS_TWO      14'h121A
`define IDX_MS_THREE    14'h121C
`define PAIR_COUNT      6
`define PAIR_RANGE_CNT  2
`define SRC_LAST_LINEAR 16'h0007
`define SRC_COMPUTED    16'h000A
`define RUN_FIRST       16'h0001
`define RUN_LAST        16'h0005
`define SPEED_MIN       16'h001E
`define TOP_MAX         16'h0190
`define SWITCH_LAST     16'h0004
`define SECOND_LAST     16'h0003
`define FLAG_LAST       16'h0001
`define VOLT_MAX        16'h0064
`define FILTER_FIRST    16'h0001
`define FILTER_LAST     16'h001F
`define RANGE_SPD_MAX   32'h00009C40
`define PRESET_MIN      32'h00000032
`define HZ_TO_CENTI     32'h00000064
`define RST_ZERO        16'h0000
`define RST_RUN_ORIGIN  16'h0001
`define RST_SPEED       16'h0032
`define RST_FILTER      16'h0008
`define RST_PAIR        32'h00000000
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

/* File: drive_bank_pkg.sv */
// Types shared by the parameter bank files.
// Assumes drive_bank_cfg.svh supplies the widths.
`include "drive_bank_cfg.svh"
package drive_bank_pkg;
   typedef struct packed {
      logic [`IDX_W-1:0] idx;
      logic [`REG_W-1:0] data;
      logic              full;
   } wr_req_s;
   typedef struct packed {
      logic [15:0] speed_source_select;
      logic [15:0] run_origin_select;
      logic [15:0] base_speed;
      logic [15:0] top_speed;
      logic [15:0] input_switch_mode;
      logic [15:0] second_input_mode;
      logic [31:0] range_start_speed;
      logic [31:0] range_end_speed;
      logic [15:0] range_start_voltage;
      logic [15:0] range_end_voltage;
      logic [15:0] range_start_behaviour;
      logic [15:0] input_filter_constant;
      logic [15:0] sequence_program_enable;
      logic [15:0] multispeed_mode;
      logic [31:0] multispeed_base_value;
      logic [31:0] multispeed_preset_one;
      logic [31:0] multispeed_preset_two;
      logic [31:0] multispeed_preset_three;
   } param_bank_s;
endpackage : drive_bank_pkg

/* File: drive_param_bank.sv */
// Speed-source and multispeed parameter bank of a motor drive.
// Assumes one AXI4-Lite master on sys_clk and a synchronous reset.
// Overview of operation
// (R1) Speed source takes 0 to 7 or 10; other codes are refused.
// (R2) Run origin takes codes 1 to 5 only; 0 is refused.
// (R3) Top speed 30 to 400 Hz; base speed 30 up to top speed.
// (R4) Input switch mode selects one of five input pairs, codes 0 to 4.
// (R5) Second input mode takes codes 0 to 3.
// (R6) Range start speed is a high/low pair, 0 to 40000 centihertz.
// (R7) Range end speed is a high/low pair, 0 to 40000 centihertz.
// (R8) Start voltage 0 to end voltage; end voltage start to 100 percent.
// (R9) Range start behaviour takes 0 or 1.
// (R10) Filter constant takes 1 to 30, or 31 for fixed filtering.
// (R11) Sequence program enable takes 0 or 1.
// (R12) Multispeed presets are pairs: 0, or start speed to top speed.
// (R13) Reserved and unmapped addresses ignore writes and read as errors.
// (R14) Out-of-range writes are refused and leave the old value.
`timescale 1ns/10ps
`default_nettype none
`include "drive_bank_cfg.svh"
module drive_param_bank (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire logic [`ADDR_W-1:0]     awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [`ADDR_W-1:0]     araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   output drive_bank_pkg::param_bank_s params
);
   localparam logic [`IDX_W-1:0] PAIR_BASE [`PAIR_COUNT] = '{
      `IDX_RSTART_SPD, `IDX_REND_SPD, `IDX_MS_BASE,
      `IDX_MS_ONE, `IDX_MS_TWO, `IDX_MS_THREE};

   drive_bank_pkg::wr_req_s wr_req;
   logic                    wr_go;
   logic                    wr_ok;
   logic                    wr_accept;
   logic [`IDX_W-1:0]       rd_idx;
   logic                    rd_go;
   logic [15:0]             rd_data;
   logic                    rd_ok;
   logic [15:0]             d;
   logic [31:0]             top_centi;
   logic [15:0]             speed_source_select;
   logic [15:0]             run_origin_select;
   logic [15:0]             base_speed;
   logic [15:0]             top_speed;
   logic [15:0]             input_switch_mode;
   logic [15:0]             second_input_mode;
   logic [15:0]             range_start_voltage;
   logic [15:0]             range_end_voltage;
   logic [15:0]             range_start_behaviour;
   logic [15:0]             input_filter_constant;
   logic [15:0]             sequence_program_enable;
   logic [15:0]             multispeed_mode;
   logic [31:0]             pair_value  [`PAIR_COUNT];
   logic                    pair_low_ok [`PAIR_COUNT];
   logic [`PAIR_COUNT-1:0]  pair_hi_we;
   logic [`PAIR_COUNT-1:0]  pair_lo_we;

   axil_front front (
      .sys_clk (sys_clk),
      .reset   (reset),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_req  (wr_req),
      .wr_go   (wr_go),
      .wr_ok   (wr_ok),
      .rd_idx  (rd_idx),
      .rd_go   (rd_go),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   assign d         = wr_req.data;
   assign wr_accept = wr_go && wr_ok;
   assign top_centi = {16'h0000, top_speed} * `HZ_TO_CENTI;

   // Speed pairs: the two range speeds, then the multispeed presets
   genvar k;
   generate
      for (k = 0; k < `PAIR_COUNT; k++) begin : g_pair
         assign pair_hi_we[k] = wr_go && wr_req.full
                                && wr_req.idx == PAIR_BASE[k];
         assign pair_lo_we[k] = wr_go && wr_req.full
                                && wr_req.idx == PAIR_BASE[k] + 1'b1;
         speed_pair pair (
            .sys_clk (sys_clk),
            .reset   (reset),
            .wr_high (pair_hi_we[k]),
            .wr_low  (pair_lo_we[k]),
            .data    (d),
            .lo      (k < `PAIR_RANGE_CNT ? `RST_PAIR : `PRESET_MIN),
            .hi      (k < `PAIR_RANGE_CNT ? `RANGE_SPD_MAX : top_centi),
            .zero_ok (1'b1),
            .value   (pair_value[k]),
            .low_ok  (pair_low_ok[k])
         );
      end
   endgenerate

   // Range check of the addressed word; anything unlisted is refused
   always_comb begin
      wr_ok = 1'b0;
      case (wr_req.idx)
         `IDX_SPEED_SRC:   wr_ok = d <= `SRC_LAST_LINEAR
                                   || d == `SRC_COMPUTED; // R1
         `IDX_RUN_ORIGIN:  wr_ok = d >= `RUN_FIRST
                                   && d <= `RUN_LAST; // R2
         `IDX_BASE_SPEED:  wr_ok = d >= `SPEED_MIN
                                   && d <= top_speed; // R3
         `IDX_TOP_SPEED:   wr_ok = d >= `SPEED_MIN && d <= `TOP_MAX
                                   && d >= base_speed; // R3
         `IDX_SWITCH_MODE: wr_ok = d <= `SWITCH_LAST; // R4
         `IDX_SECOND_MODE: wr_ok = d <= `SECOND_LAST; // R5
         `IDX_RSTART_VOLT: wr_ok = d <= range_end_voltage; // R8
         `IDX_REND_VOLT:   wr_ok = d >= range_start_voltage
                                   && d <= `VOLT_MAX; // R8
         `IDX_RSTART_BEH:  wr_ok = d <= `FLAG_LAST; // R9
         `IDX_FILTER:      wr_ok = d >= `FILTER_FIRST
                                   && d <= `FILTER_LAST; // R10
         `IDX_SEQ_ENABLE:  wr_ok = d <= `FLAG_LAST; // R11
         `IDX_MS_MODE:     wr_ok = d <= `FLAG_LAST;
         default:          wr_ok = 1'b0; // R13
      endcase
      for (int i = 0; i < `PAIR_COUNT; i++) begin
         if (pair_hi_we[i]) wr_ok = 1'b1;
         if (pair_lo_we[i]) wr_ok = pair_low_ok[i]; // R6 R7 R12
      end
      wr_ok = wr_ok && wr_req.full; // R14
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         speed_source_select <= `RST_ZERO;
         run_origin_select   <= `RST_RUN_ORIGIN;
         base_speed          <= `RST_SPEED;
         top_speed           <= `RST_SPEED;
         input_switch_mode   <= `RST_ZERO;
         second_input_mode   <= `RST_ZERO;
      end else if (wr_accept) begin // R14
         case (wr_req.idx)
            `IDX_SPEED_SRC:   speed_source_select <= d; // R1
            `IDX_RUN_ORIGIN:  run_origin_select   <= d; // R2
            `IDX_BASE_SPEED:  base_speed          <= d; // R3
            `IDX_TOP_SPEED:   top_speed           <= d; // R3
            `IDX_SWITCH_MODE: input_switch_mode   <= d; // R4
            `IDX_SECOND_MODE: second_input_mode   <= d; // R5
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         range_start_voltage     <= `RST_ZERO;
         range_end_voltage       <= `VOLT_MAX;
         range_start_behaviour   <= `RST_ZERO;
         input_filter_constant   <= `RST_FILTER;
         sequence_program_enable <= `RST_ZERO;
         multispeed_mode         <= `RST_ZERO;
      end else if (wr_accept) begin // R14
         case (wr_req.idx)
            `IDX_RSTART_VOLT: range_start_voltage     <= d; // R8
            `IDX_REND_VOLT:   range_end_voltage       <= d; // R8
            `IDX_RSTART_BEH:  range_start_behaviour   <= d; // R9
            `IDX_FILTER:      input_filter_constant   <= d; // R10
            `IDX_SEQ_ENABLE:  sequence_program_enable <= d; // R11
            `IDX_MS_MODE:     multispeed_mode         <= d;
            default: ;
         endcase
      end
   end

   // Read mux; reserved and unmapped words answer with an error
   always_comb begin
      rd_ok   = 1'b1;
      rd_data = `RST_ZERO;
      case (rd_idx)
         `IDX_SPEED_SRC:   rd_data = speed_source_select;
         `IDX_RUN_ORIGIN:  rd_data = run_origin_select;
         `IDX_BASE_SPEED:  rd_data = base_speed;
         `IDX_TOP_SPEED:   rd_data = top_speed;
         `IDX_SWITCH_MODE: rd_data = input_switch_mode;
         `IDX_SECOND_MODE: rd_data = second_input_mode;
         `IDX_RSTART_VOLT: rd_data = range_start_voltage;
         `IDX_REND_VOLT:   rd_data = range_end_voltage;
         `IDX_RSTART_BEH:  rd_data = range_start_behaviour;
         `IDX_FILTER:      rd_data = input_filter_constant;
         `IDX_SEQ_ENABLE:  rd_data = sequence_program_enable;
         `IDX_MS_MODE:     rd_data = multispeed_mode;
         default:          rd_ok   = 1'b0; // R13
      endcase
      for (int i = 0; i < `PAIR_COUNT; i++) begin
         if (rd_idx == PAIR_BASE[i]) begin
            rd_ok   = 1'b1;
            rd_data = pair_value[i][31:16]; // R6 R7 R12
         end
         if (rd_idx == PAIR_BASE[i] + 1'b1) begin
            rd_ok   = 1'b1;
            rd_data = pair_value[i][15:0];
         end
      end
   end

   assign params.speed_source_select     = speed_source_select;
   assign params.run_origin_select       = run_origin_select;
   assign params.base_speed              = base_speed;
   assign params.top_speed               = top_speed;
   assign params.input_switch_mode       = input_switch_mode;
   assign params.second_input_mode       = second_input_mode;
   assign params.range_start_speed       = pair_value[0];
   assign params.range_end_speed         = pair_value[1];
   assign params.range_start_voltage     = range_start_voltage;
   assign params.range_end_voltage       = range_end_voltage;
   assign params.range_start_behaviour   = range_start_behaviour;
   assign params.input_filter_constant   = input_filter_constant;
   assign params.sequence_program_enable = sequence_program_enable;
   assign params.multispeed_mode         = multispeed_mode;
   assign params.multispeed_base_value   = pair_value[2];
   assign params.multispeed_preset_one   = pair_value[3];
   assign params.multispeed_preset_two   = pair_value[4];
   assign params.multispeed_preset_three = pair_value[5];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   source_code_a: assert property ( // R1
      speed_source_select <= `SRC_LAST_LINEAR
      || speed_source_select == `SRC_COMPUTED)
      else $error("speed source holds an undefined code");
   source_write_a: assert property ( // R1
      wr_go && wr_req.full && wr_req.idx == `IDX_SPEED_SRC
      && d == `SRC_COMPUTED |=> speed_source_select == `SRC_COMPUTED)
      else $error("computed-result source code not stored");
   run_origin_a: assert property ( // R2
      wr_go && wr_req.idx == `IDX_RUN_ORIGIN && d == `RST_ZERO
      |=> $stable(run_origin_select))
      else $error("run origin took code zero");
   speed_order_a: assert property ( // R3
      top_speed <= `TOP_MAX && base_speed >= `SPEED_MIN
      && base_speed <= top_speed)
      else $error("base or top speed out of range");
   mode_codes_a: assert property ( // R4
      input_switch_mode <= `SWITCH_LAST
      && second_input_mode <= `SECOND_LAST) // R5
      else $error("input mode code out of range");
   range_speed_a: assert property ( // R6
      pair_value[0] <= `RANGE_SPD_MAX
      && pair_value[1] <= `RANGE_SPD_MAX) // R7
      else $error("range speed above limit");
   volt_order_a: assert property ( // R8
      range_start_voltage <= range_end_voltage
      && range_end_voltage <= `VOLT_MAX)
      else $error("active range voltages out of order");
   flag_codes_a: assert property ( // R9
      range_start_behaviour <= `FLAG_LAST
      && sequence_program_enable <= `FLAG_LAST) // R11
      else $error("flag register above one");
   filter_range_a: assert property ( // R10
      input_filter_constant >= `FILTER_FIRST
      && input_filter_constant <= `FILTER_LAST)
      else $error("filter constant out of range");
   preset_range_a: assert property ( // R12
      pair_lo_we[2] && pair_low_ok[2]
      |=> pair_value[2] == '0 || pair_value[2] >= `PRESET_MIN)
      else $error("multispeed base value below start speed");
   reserved_word_a: assert property ( // R13
      rd_go && !rd_ok |=> rvalid && rresp == `RESP_SLVERR
      && rdata == '0)
      else $error("reserved read not answered with error");
   reject_hold_a: assert property ( // R14
      wr_go && !wr_ok |=> $stable(params) && bvalid
      && bresp == `RESP_SLVERR)
      else $error("refused write changed the bank");
   pair_stage_a: assert property ( // R12
      pair_hi_we[3] |=> $stable(pair_value[3]))
      else $error("staged high word changed a committed preset");
   preset_top_a: assert property ( // R12
      pair_lo_we[3] && pair_low_ok[3]
      |=> pair_value[3] == '0 || pair_value[3] <= top_centi)
      else $error("multispeed preset above top speed");
   strobe_refuse_a: assert property ( // R14
      wr_go && !wr_req.full |=> bvalid && bresp == `RESP_SLVERR)
      else $error("partial-strobe write not refused");
   range_hold_a: assert property ( // R6
      pair_hi_we[0] |=> $stable(pair_value[0]))
      else $error("range start speed changed on a high-word write");

   write_ok_c: cover property (wr_go && wr_ok);
   write_refused_c: cover property (wr_go && !wr_ok);
   pair_commit_c: cover property (pair_lo_we[3] && pair_low_ok[3]);
   read_error_c: cover property (rd_go && !rd_ok);
   top_limit_c: cover property (wr_go && wr_ok
      && wr_req.idx == `IDX_TOP_SPEED);
endmodule : drive_param_bank
`default_nettype wire

/* File: speed_pair.sv */
// One 32-bit speed value written as a high word then a low word.
// Assumes the low-word write commits; the high word is only staged.
`timescale 1ns/10ps
`default_nettype none
`include "drive_bank_cfg.svh"
module speed_pair (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        wr_high,
   input  wire logic        wr_low,
   input  wire logic [15:0] data,
   input  wire logic [31:0] lo,
   input  wire logic [31:0] hi,
   input  wire logic        zero_ok,
   output logic      [31:0] value,
   output logic             low_ok
);
   logic [15:0] hold;
   logic [31:0] cand;

   assign cand   = {hold, data};
   assign low_ok = (cand >= lo && cand <= hi) || (zero_ok && cand == '0);

   always_ff @(posedge sys_clk) begin
      if (reset) hold <= `RST_ZERO;
      else if (wr_high) hold <= data;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) value <= `RST_PAIR;
      else if (wr_low && low_ok) value <= cand;
   end
endmodule : speed_pair
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the drive parameter bank over AXI4-Lite.
// Assumes the bank answers each request within the timeout ceiling.
`timescale 1ns/10ps
`default_nettype none
`include "drive_bank_cfg.svh"
module tb;
   logic                        sys_clk = '0;
   logic                        reset = '1;
   logic [15:0]                 awaddr = '0;
   logic [15:0]                 araddr = '0;
   logic                        awvalid = '0;
   logic                        wvalid = '0;
   logic                        bready = '0;
   logic                        arvalid = '0;
   logic                        rready = '0;
   logic [31:0]                 wdata = '0;
   logic [3:0]                  wstrb = 4'hF;
   logic                        awready, wready, bvalid, arready, rvalid;
   logic [1:0]                  bresp, rresp;
   logic [31:0]                 rdata;
   drive_bank_pkg::param_bank_s params;
   int                          n_fail = 0;
   int                          n_compared = 0;
   int                          cyc = 0;
   localparam logic [1:0]       OK = `RESP_OKAY;
   localparam logic [1:0]       ER = `RESP_SLVERR;

   drive_param_bank i_dut (.sys_clk, .reset, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .params);

   always #25 sys_clk = ~sys_clk;

   task automatic print_verdict;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] g, x, input string m);
      n_compared++;
      if (g !== x) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk

   // Values are sampled at the falling edge, where all outputs are settled
   task automatic wr(input logic [13:0] i, input logic [15:0] d,
                     input logic [1:0] e);
      logic       ta, tw, tb;
      logic [1:0] g;
      @(posedge sys_clk);
      awaddr  <= {i, 2'h0};
      wdata   <= {16'h0000, d};
      awvalid <= '1;
      wvalid  <= '1;
      bready  <= '1;
      do begin
         @(negedge sys_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         g  = bresp;
         @(posedge sys_clk);
         if (ta) awvalid <= '0;
         if (tw) wvalid <= '0;
      end while (!tb);
      bready <= '0;
      chk(g, e, "write response");
   endtask : wr

   task automatic rd(input logic [13:0] i, input logic [1:0] e,
                     input logic [15:0] d);
      logic        ta, tr;
      logic [1:0]  g;
      logic [31:0] gd;
      @(posedge sys_clk);
      araddr  <= {i, 2'h0};
      arvalid <= '1;
      rready  <= '1;
      do begin
         @(negedge sys_clk);
         ta = arvalid && arready;
         tr = rvalid;
         g  = rresp;
         gd = rdata;
         @(posedge sys_clk);
         if (ta) arvalid <= '0;
      end while (!tr);
      rready <= '0;
      chk(g, e, "read response");
      chk(gd, {16'h0000, d}, "read data");
   endtask : rd

   // Every code 0..top is written; refused ones must leave the old value
   task automatic sw(input logic [13:0] i, input int top, lo, hi, x,
                     input logic [15:0] r);
      logic ok;
      for (int v = 0; v <= top; v++) begin
         ok = (v >= lo && v <= hi) || v == x;
         if (ok) r = 16'(v);
         wr(i, 16'(v), ok ? OK : ER);
         rd(i, OK, r);
      end
   endtask : sw

   task automatic pw(input logic [13:0] b, input logic [31:0] v,
                     input logic [1:0] e);
      wr(b, v[31:16], OK);
      wr(b + 14'h0001, v[15:0], e);
   endtask : pw

   task automatic pr(input logic [13:0] b, input logic [31:0] v);
      rd(b, OK, v[31:16]);
      rd(b + 14'h0001, OK, v[15:0]);
   endtask : pr

   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= '0;
      rd(`IDX_RUN_ORIGIN, OK, `RST_RUN_ORIGIN);
      rd(`IDX_REND_VOLT, OK, `VOLT_MAX);
      rd(`IDX_FILTER, OK, `RST_FILTER);
      $display("test reset values done");
      sw(`IDX_SPEED_SRC, 11, 0, 7, 10, `RST_ZERO);
      sw(`IDX_RUN_ORIGIN, 6, 1, 5, -1, `RST_RUN_ORIGIN);
      sw(`IDX_SWITCH_MODE, 5, 0, 4, -1, `RST_ZERO);
      sw(`IDX_SECOND_MODE, 4, 0, 3, -1, `RST_ZERO);
      sw(`IDX_RSTART_BEH, 2, 0, 1, -1, `RST_ZERO);
      sw(`IDX_FILTER, 32, 1, 30, 31, `RST_FILTER);
      sw(`IDX_SEQ_ENABLE, 2, 0, 1, -1, `RST_ZERO);
      sw(`IDX_MS_MODE, 2, 0, 1, -1, `RST_ZERO);
      $display("test codes done");
      wr(`IDX_TOP_SPEED, 16'h0191, ER);
      wr(`IDX_TOP_SPEED, 16'h0190, OK);
      wr(`IDX_BASE_SPEED, 16'h0191, ER);
      wr(`IDX_BASE_SPEED, 16'h0190, OK);
      wr(`IDX_TOP_SPEED, 16'h0064, ER);
      wr(`IDX_BASE_SPEED, 16'h001D, ER);
      wr(`IDX_BASE_SPEED, 16'h001E, OK);
      wr(`IDX_TOP_SPEED, 16'h001D, ER);
      wr(`IDX_TOP_SPEED, 16'h001E, OK);
      rd(`IDX_BASE_SPEED, OK, 16'h001E);
      chk(32'(params.top_speed), 32'h0000001E, "top speed");
      wr(`IDX_RSTART_VOLT, 16'h003C, OK);
      wr(`IDX_REND_VOLT, 16'h003B, ER);
      wr(`IDX_REND_VOLT, 16'h0065, ER);
      wr(`IDX_REND_VOLT, 16'h003C, OK);
      wr(`IDX_RSTART_VOLT, 16'h003D, ER);
      rd(`IDX_RSTART_VOLT, OK, 16'h003C);
      $display("test limits done");
      pw(`IDX_RSTART_SPD, 32'h00009C40, OK);
      pw(`IDX_RSTART_SPD, 32'h00009C41, ER);
      pr(`IDX_RSTART_SPD, 32'h00009C40);
      pw(`IDX_REND_SPD, 32'h00010000, ER);
      pr(`IDX_REND_SPD, 32'h00000000);
      pw(`IDX_REND_SPD, 32'h00001234, OK);
      pr(`IDX_REND_SPD, 32'h00001234);
      pw(`IDX_MS_BASE, 32'h00000BB8, OK);
      pw(`IDX_MS_ONE, 32'h00000BB9, ER);
      pw(`IDX_MS_TWO, 32'h00000031, ER);
      pw(`IDX_MS_TWO, 32'h00000032, OK);
      pw(`IDX_MS_TWO, 32'h00000000, OK);
      pr(`IDX_MS_ONE, 32'h00000000);
      pw(`IDX_MS_ONE, 32'h00000BB8, OK);
      pw(`IDX_MS_THREE, 32'h00000064, OK);
      pr(`IDX_MS_THREE, 32'h00000064);
      pr(`IDX_MS_TWO, 32'h00000000);
      chk(params.multispeed_preset_one, 32'h00000BB8, "preset one");
      chk(params.range_end_speed, 32'h00001234, "range end");
      chk(params.multispeed_base_value, 32'h00000BB8, "preset");
      $display("test pairs done");
      wr(14'h1207, 16'h0001, ER);
      rd(14'h1207, ER, 16'h0000);
      wr(14'h1214, 16'h0001, ER);
      rd(14'h1214, ER, 16'h0000);
      rd(14'h1300, ER, 16'h0000);
      wstrb <= 4'h1;
      wr(`IDX_SEQ_ENABLE, 16'h0000, ER);
      wstrb <= 4'hF;
      rd(`IDX_SEQ_ENABLE, OK, 16'h0001);
      $display("test refusals done");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
